// >>> logic/param_telegram_master.v
// Notes on behaviour
// R1 - index is two bytes; only the low byte selects the array entry
// R2 - value block is two 16-bit words; meaning follows the command code
// R3 - a read request goes out with an empty (zero) value block
// R4 - a write request carries the new value in the value block
// R5 - device returns the present value in its response value block
// R6 - option-list parameters travel as their option value
// R7 - text reading only for parameters of the text data type
// R8 - text read is command F with index high byte 4
// R9 - text write is command F with index high byte 5
// R10 - text telegrams vary in length; the length byte carries it
// R11 - data type codes 3,4,5,6,7,9,10,13,33,35; unsigned has no sign
// R12 - values travel as integers scaled by ten to the conversion index
// R13 - process words: control then reference out, status then frequency back
// R14 - single word write to RAM and EEPROM uses command E
// R15 - only the master starts transactions; slaves only answer
// R16 - device answers only queries addressed to it alone
// R17 - device never answers a broadcast query
// R18 - query holds address, function, data and a trailing check field
// R19 - on a bad or impossible query device answers error or stays silent
// R20 - control word, reference and parameter access are reachable
// R21 - command code sits in key bits 15..12 with the listed codes
// R22 - parameter number sits in key bits 11..0
// R23 - code 0111 answers an impossible command, fault code in value
// R24 - text command with index high not 4 or 5 is not executable
// R25 - conversion index never alters the transferred integer
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/10ps
`include "param_telegram_defines.vh"

module param_telegram_master #(
  parameter RESP_TIMEOUT_CYCLES = `RESP_TIMEOUT_US * `CLK_MHZ
) (
  input wire clk_sys,
  input wire srst,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  output reg [7:0] tx_byte,
  output reg tx_valid,
  output reg tx_last,
  input wire tx_ready,
  output reg [7:0] telegram_length_byte,
  output reg tx_broadcast,
  input wire [7:0] rx_byte,
  input wire rx_valid,
  input wire rx_last
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_FETCH = 3'h1;
  localparam [2:0] S_SEND = 3'h2;
  localparam [2:0] S_WAIT = 3'h3;
  localparam [2:0] S_EVAL = 3'h4;
  // load value cut to the width of the down counter
  localparam [31:0] TIMEOUT_FULL = RESP_TIMEOUT_CYCLES;
  localparam [23:0] TIMEOUT_LOAD = TIMEOUT_FULL[23:0];

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  reg [2:0] state;
  reg [3:0] cmd;
  reg [7:0] index_high;
  reg [5:0] data_type;
  reg [2:0] text_count;
  wire broadcast;
  reg [3:0] cur_cmd;
  reg cur_text_read;
  reg [2:0] cur_n;
  reg [3:0] pos;
  reg [3:0] rx_cnt;
  reg [23:0] timer;
  reg [15:0] rsp_key;
  reg [31:0] rsp_pwe;
  reg [31:0] rsp_pcd;
  reg [31:0] rsp_value;
  reg [15:0] fault_code;
  reg st_done;
  reg st_timeout;
  reg st_fault;
  reg st_refused;
  wire [15:0] mem_q;
  wire wr_word;
  wire [2:0] mem_waddr;
  wire [3:0] n_plus4;
  wire [3:0] lp;
  wire [3:0] total;
  wire zero_value;
  wire start;
  wire text_ok;

  // ----------------------------------------------------------------
  // software writes into the outgoing word store
  // ----------------------------------------------------------------
  // words 0..5: key, index, value high, value low, control, reference
  assign wr_word = wr && (addr >= `REG_KEY) && (addr <= `REG_PCD_REFERENCE);
  assign mem_waddr = addr[4:2] - 3'h1;

  // byte position to word position, skipping unused text bytes
  assign n_plus4 = {1'b0, cur_n} + 4'h4;
  assign lp = (pos < n_plus4) ? pos : (pos + 4'h4 - {1'b0, cur_n}); // R10
  assign total = n_plus4 + 4'h4;

  // a read asks with an empty value block
  assign zero_value = (lp[3:2] == 2'h1) &&
                      ((cur_cmd == `CMD_READ) || cur_text_read); // R3

  tx_word_mem u_mem (
    .clk_sys(clk_sys),
    .we(wr_word),
    .waddr(mem_waddr),
    .wdata(wdata[15:0]),
    .raddr(lp[3:1]),
    .rdata(mem_q)
  );

  // ----------------------------------------------------------------
  // start checks
  // ----------------------------------------------------------------
  assign start = wr && (addr == `REG_CTRL) && wdata[`CTRL_START];
  // the broadcast choice rides on the start write itself; a stored copy
  // would only update at the same edge and lag one transaction behind
  assign broadcast = wdata[`CTRL_BROADCAST]; // R17 R18

  // text needs index high 4 or 5, and reading needs a text type
  assign text_ok = (index_high == `TEXT_WRITE_HIGH) || // R9 R24
                   ((index_high == `TEXT_READ_HIGH) && // R8
                    (data_type == `DT_TEXT)); // R7

  // ----------------------------------------------------------------
  // shadow copies of fields the sequencer looks at
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (srst) begin
      cmd <= `CMD_NONE;
      index_high <= 8'h00;
      data_type <= `DT_UINT16;
      text_count <= 3'h0;
    end else if (wr) begin
      case (addr)
        `REG_KEY: begin
          cmd <= wdata[`KEY_CODE_MSB:`KEY_CODE_LSB]; // R14 R21
        end
        `REG_INDEX: begin
          index_high <= wdata[15:8]; // R1
        end
        `REG_TYPE: begin
          data_type <= wdata[5:0]; // R11
          text_count <= (wdata[10:8] > `VALUE_BYTES) ? `VALUE_BYTES : wdata[10:8];
        end
        // other offsets only reach the word store or the sequencer
        default: begin
          cmd <= cmd;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // transaction sequencer
  // ----------------------------------------------------------------
  // one transaction at a time, always started from this side
  always @(posedge clk_sys) begin
    if (srst) begin
      state <= S_IDLE;
      cur_cmd <= `CMD_NONE;
      cur_text_read <= 1'b0;
      cur_n <= `VALUE_BYTES;
      pos <= 4'h0;
      rx_cnt <= 4'h0;
      timer <= 24'h000000;
      tx_byte <= 8'h00;
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
      telegram_length_byte <= 8'h00;
      tx_broadcast <= 1'b0;
      rsp_key <= 16'h0000;
      rsp_pwe <= 32'h00000000;
      rsp_pcd <= 32'h00000000;
      rsp_value <= 32'h00000000;
      fault_code <= 16'h0000;
      st_done <= 1'b0;
      st_timeout <= 1'b0;
      st_fault <= 1'b0;
      st_refused <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          if (start) begin // R15
            st_done <= 1'b0;
            st_timeout <= 1'b0;
            st_fault <= 1'b0;
            st_refused <= 1'b0;
            // a refused text command finishes at once and sends nothing
            if ((cmd == `CMD_TEXT) && !text_ok) begin
              st_refused <= 1'b1; // R24
              st_done <= 1'b1;
            end else begin
              cur_cmd <= cmd;
              cur_text_read <= (cmd == `CMD_TEXT) && (index_high == `TEXT_READ_HIGH);
              cur_n <= (cmd == `CMD_TEXT) ? text_count : `VALUE_BYTES; // R2
              telegram_length_byte <= `TEXT_FIXED_LEN +
                ((cmd == `CMD_TEXT) ? {5'h00, text_count} : {5'h00, `VALUE_BYTES}); // R10
              tx_broadcast <= broadcast; // R18
              pos <= 4'h0;
              state <= S_FETCH;
            end
          end
        end
        S_FETCH: begin
          // store output for this position is ready next cycle
          state <= S_SEND;
        end
        S_SEND: begin
          if (!tx_valid) begin
            // key, index, value, control then reference, high byte first
            if (zero_value) begin
              tx_byte <= 8'h00;
            end else if (lp[0]) begin
              tx_byte <= mem_q[7:0]; // R4 R13
            end else begin
              tx_byte <= mem_q[15:8]; // R22
            end
            tx_last <= (pos == total - 4'h1);
            tx_valid <= 1'b1;
          end else if (tx_ready) begin
            tx_valid <= 1'b0;
            tx_last <= 1'b0;
            pos <= pos + 4'h1;
            if (pos == total - 4'h1) begin
              rx_cnt <= 4'h0;
              timer <= TIMEOUT_LOAD;
              rsp_pwe <= 32'h00000000;
              if (tx_broadcast) begin
                st_done <= 1'b1; // R17
                state <= S_IDLE;
              end else begin
                state <= S_WAIT; // R16
              end
            end else begin
              state <= S_FETCH;
            end
          end
        end
        S_WAIT: begin
          if (rx_valid) begin
            if (rx_cnt != 4'hf) begin
              rx_cnt <= rx_cnt + 4'h1;
            end
            if (rx_cnt < 4'h2) begin
              rsp_key <= {rsp_key[7:0], rx_byte};
            end else if ((rx_cnt >= 4'h4) && (rx_cnt < 4'h8)) begin
              rsp_pwe <= {rsp_pwe[23:0], rx_byte}; // R5
            end
            // last four bytes are status then frequency
            rsp_pcd <= {rsp_pcd[23:0], rx_byte}; // R13
            if (rx_last) begin
              state <= S_EVAL;
            end
            // the drive may stay silent on a bad query, so the wait is bounded
          end else if (timer == 24'h000000) begin
            st_timeout <= 1'b1; // R19
            st_done <= 1'b1;
            state <= S_IDLE;
          end else begin
            timer <= timer - 24'h000001;
          end
        end
        S_EVAL: begin
          // integer kept as sent; scaling is left to software
          case (rsp_key[`KEY_CODE_MSB:`KEY_CODE_LSB])
            `RSP_WORD: begin
              if (data_type == `DT_INT16) begin
                rsp_value <= {{16{rsp_pwe[15]}}, rsp_pwe[15:0]}; // R11 R25
              end else begin
                rsp_value <= {16'h0000, rsp_pwe[15:0]}; // R6
              end
            end
            `RSP_CANNOT: begin
              st_fault <= 1'b1; // R23
              fault_code <= rsp_pwe[15:0];
              rsp_value <= rsp_pwe;
            end
            default: begin
              rsp_value <= rsp_pwe; // R12
            end
          endcase
          st_done <= 1'b1;
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // software read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (srst) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      case (addr)
        `REG_CTRL: begin
          rdata <= {27'h0000000, st_refused, st_fault, st_timeout,
                    st_done, (state != S_IDLE)};
        end
        `REG_KEY: begin
          rdata <= {28'h0000000, cmd};
        end
        `REG_INDEX: begin
          rdata <= {24'h000000, index_high};
        end
        `REG_TYPE: begin
          rdata <= {21'h000000, text_count, 2'h0, data_type};
        end
        `REG_RESP_KEY: begin
          rdata <= {16'h0000, rsp_key};
        end
        `REG_RESP_VALUE: begin
          rdata <= rsp_value;
        end
        `REG_RESP_PCD: begin
          rdata <= {rsp_pcd[15:0], rsp_pcd[31:16]};
        end
        `REG_FAULT: begin
          rdata <= {16'h0000, fault_code};
        end
        default: begin
          rdata <= 32'h00000000;
        end
      endcase
    end
  end

endmodule

// >>> logic/param_telegram_defines.vh
`ifndef PARAM_TELEGRAM_DEFINES_VH
`define PARAM_TELEGRAM_DEFINES_VH

// ----------------------------------------------------------------
// software register byte offsets
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_KEY 8'h04
`define REG_INDEX 8'h08
`define REG_VALUE_HIGH 8'h0c
`define REG_VALUE_LOW 8'h10
`define REG_PCD_CONTROL 8'h14
`define REG_PCD_REFERENCE 8'h18
`define REG_TYPE 8'h1c
`define REG_RESP_KEY 8'h20
`define REG_RESP_VALUE 8'h24
`define REG_RESP_PCD 8'h28
`define REG_FAULT 8'h2c

// ----------------------------------------------------------------
// control and status bit positions
// ----------------------------------------------------------------
`define CTRL_START 0
`define CTRL_BROADCAST 1
`define ST_BUSY 0
`define ST_DONE 1
`define ST_TIMEOUT 2
`define ST_FAULT 3
`define ST_REFUSED 4

// ----------------------------------------------------------------
// parameter key word layout and codes
// ----------------------------------------------------------------
`define KEY_CODE_MSB 15
`define KEY_CODE_LSB 12
`define KEY_NUM_MSB 11
`define KEY_NUM_LSB 0
`define CMD_NONE 4'h0
`define CMD_READ 4'h1
`define CMD_WRITE_WORD 4'h2
`define CMD_WRITE_DWORD 4'h3
`define CMD_EE_DWORD 4'hd
`define CMD_EE_WORD 4'he
`define CMD_TEXT 4'hf
`define RSP_WORD 4'h1
`define RSP_DWORD 4'h2
`define RSP_CANNOT 4'h7
`define RSP_TEXT 4'hf
`define TEXT_READ_HIGH 8'h04
`define TEXT_WRITE_HIGH 8'h05

// ----------------------------------------------------------------
// data type codes
// ----------------------------------------------------------------
`define DT_INT16 6'h03
`define DT_INT32 6'h04
`define DT_UINT8 6'h05
`define DT_UINT16 6'h06
`define DT_UINT32 6'h07
`define DT_TEXT 6'h09
`define DT_BYTES 6'h0a
`define DT_TIME_DIFF 6'h0d
`define DT_RESERVED 6'h21
`define DT_BITS 6'h23

// ----------------------------------------------------------------
// telegram sizes and timing
// ----------------------------------------------------------------
`define TEXT_FIXED_LEN 8'h0a
`define VALUE_BYTES 3'h4
`define CLK_MHZ 200
`define RESP_TIMEOUT_US 10000

`endif

// >>> logic/tx_word_mem.v
`timescale 1ns/10ps
// ----------------------------------------------------------------
// eight by sixteen word store, registered read
// ----------------------------------------------------------------
module tx_word_mem (
  input wire clk_sys,
  input wire we,
  input wire [2:0] waddr,
  input wire [15:0] wdata,
  input wire [2:0] raddr,
  output reg [15:0] rdata
);

  reg [15:0] mem [0:7];

  // write port and registered read port
  always @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// >>> tb/param_telegram_chk.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module param_telegram_chk #(
  parameter RESP_TIMEOUT_CYCLES = 50
) (
  input wire clk_sys,
  input wire srst,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata,
  input wire [7:0] tx_byte,
  input wire tx_valid,
  input wire tx_last,
  input wire tx_ready,
  input wire [7:0] telegram_length_byte,
  input wire tx_broadcast,
  input wire [7:0] rx_byte,
  input wire rx_valid,
  input wire rx_last
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // offered byte must stand until taken
  sequence offer_s; tx_valid && !tx_ready; endsequence
  sequence hold_s; tx_valid && $stable(tx_byte) && $stable(tx_last); endsequence
  offer_hold_a: assert property (offer_s |=> hold_s) else $error("byte moved early");
  byte_gap_a: assert property (tx_valid && tx_ready |=> !tx_valid [*2])
    else $error("no gap after byte");
  last_valid_a: assert property (tx_last |-> tx_valid) else $error("last without valid");
  fall_cause_a: assert property ($fell(tx_valid) |-> $past(tx_ready))
    else $error("valid dropped unasked");
  len_steady_a: assert property (tx_valid |-> $stable(telegram_length_byte))
    else $error("length moved");
  len_range_a: assert property (tx_valid |-> telegram_length_byte inside {[8'h0b:8'h0e]})
    else $error("length out of range");
  bc_steady_a: assert property (tx_valid |-> $stable(tx_broadcast))
    else $error("broadcast moved");
  wo_zero_a: assert property (rd && (addr == 8'h30 || addr == 8'h0c) |=> rdata == 32'h0)
    else $error("hidden word read nonzero");
  rdata_hold_a: assert property (!rd |=> $stable(rdata)) else $error("rdata moved");
endmodule

bind param_telegram_master param_telegram_chk #(.RESP_TIMEOUT_CYCLES(RESP_TIMEOUT_CYCLES)) chk (
  .clk_sys(clk_sys), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_last(tx_last),
  .tx_ready(tx_ready), .telegram_length_byte(telegram_length_byte),
  .tx_broadcast(tx_broadcast), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_last(rx_last));

// >>> tb/drive_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// drive on the far side of the telegram link
// ----------------------------------------------------------------
module drive_model (
  input wire clk_sys,
  input wire [7:0] tx_byte,
  input wire tx_valid,
  input wire tx_last,
  output wire tx_ready,
  input wire tx_broadcast,
  input wire slow,
  input wire mute,
  output reg [7:0] rx_byte,
  output reg rx_valid,
  output reg rx_last
);
  reg [7:0] got [0:15];
  reg [15:0] mem [0:255];
  reg [7:0] rsp [0:11];
  reg phase;
  integer n;
  integer nrep;

  // stalls every other cycle when slow
  assign tx_ready = tx_valid && !(slow && phase);

  // builds and sends one twelve byte answer
  task reply;
    reg [3:0] code;
    reg [31:0] v;
    integer i;
    begin
      nrep = nrep + 1;
      code = got[0][7:4];
      v = {got[4], got[5], got[6], got[7]};
      if ({got[0][3:0], got[1]} > 12'h1ff) begin
        code = 4'h7;
        v = 32'h0;
      end else if ({got[0][3:0], got[1]} == 12'h1fe) begin
        code = 4'h7;
        v = 32'h2;
      end else if (code == 4'h1) begin
        v = {16'h0, mem[got[3]]};
      end else if (code == 4'hf) begin
        v = 32'h54455854;
      end else begin
        mem[got[3]] = v[15:0];
        code = (code == 4'h3 || code == 4'hd) ? 4'h2 : 4'h1;
      end
      rsp[0] = {code, got[0][3:0]};
      rsp[1] = got[1];
      rsp[2] = got[2];
      rsp[3] = got[3];
      for (i = 0; i < 4; i = i + 1) rsp[4 + i] = v[31 - 8 * i -: 8];
      {rsp[8], rsp[9]} = {got[n - 4], got[n - 3]};
      {rsp[10], rsp[11]} = {got[n - 2], got[n - 1]} + 16'h1;
      repeat (slow ? 6 : 2) @(posedge clk_sys);
      for (i = 0; i < 12; i = i + 1) begin
        rx_byte <= rsp[i];
        rx_valid <= 1'b1;
        rx_last <= (i == 11);
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        rx_byte <= ~rsp[i];
        @(posedge clk_sys);
      end
    end
  endtask

  // gathers query bytes, answers only individual queries
  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    rx_last = 1'b0;
    phase = 1'b0;
    n = 0;
    nrep = 0;
    forever begin
      @(posedge clk_sys);
      phase <= !phase;
      if (tx_valid && tx_ready) begin
        got[n] = tx_byte;
        n = n + 1;
        if (tx_last) begin
          if (!tx_broadcast && !mute) reply();
          n = 0;
        end
      end
    end
  end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/10ps
`include "param_telegram_defines.vh"
// ----------------------------------------------------------------
// bench top
// ----------------------------------------------------------------
module tb_top;
  reg clk_sys = 1'b0;
  reg srst = 1'b1;
  reg [7:0] addr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg slow = 1'b0;
  reg mute = 1'b0;
  wire [31:0] rdata;
  wire [7:0] tx_byte, rx_byte, len_byte;
  wire tx_valid, tx_last, tx_ready, tx_broadcast, rx_valid, rx_last;
  integer n_errors = 0;
  integer cmp_count = 0;
  reg [31:0] st;
  reg [31:0] v;

  always #2.5 clk_sys = ~clk_sys;

  param_telegram_master #(.RESP_TIMEOUT_CYCLES(50)) dut (.clk_sys(clk_sys), .srst(srst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
    .telegram_length_byte(len_byte), .tx_broadcast(tx_broadcast), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .rx_last(rx_last));
  drive_model m (.clk_sys(clk_sys), .tx_byte(tx_byte), .tx_valid(tx_valid),
    .tx_last(tx_last), .tx_ready(tx_ready), .tx_broadcast(tx_broadcast), .slow(slow),
    .mute(mute), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_last(rx_last));

  task check(input [8*12:1] what, input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("[ERR] %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task wreg(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
    end
  endtask
  task rreg(input [7:0] a, output [31:0] d);
    begin
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1 d = rdata;
    end
  endtask
  // loads one query, starts it and polls until idle
  task go(input [15:0] key, input [15:0] idx, input [31:0] val, input bc);
    integer k;
    begin
      wreg(`REG_KEY, key);
      wreg(`REG_INDEX, idx);
      wreg(`REG_VALUE_HIGH, val[31:16]);
      wreg(`REG_VALUE_LOW, val[15:0]);
      wreg(`REG_PCD_CONTROL, 32'h047f);
      wreg(`REG_PCD_REFERENCE, 32'h2000);
      wreg(`REG_CTRL, {30'h0, bc, 1'b1});
      st = 32'h1;
      for (k = 0; k < 400 && st[`ST_BUSY] !== 1'b0; k = k + 1) rreg(`REG_CTRL, st);
      check("idle", st[`ST_BUSY], 32'h0);
    end
  endtask
  task t_param;
    begin
      slow <= 1'b1;
      go(16'he19e, 16'h0000, 32'h000003e8, 1'b0);
      check("state", st, 32'h2);
      check("key", {m.got[0], m.got[1]}, 32'he19e);
      check("value out", {m.got[4], m.got[5], m.got[6], m.got[7]}, 32'h3e8);
      check("length", len_byte, 32'h0e);
      rreg(`REG_RESP_PCD, v);
      check("pcd", v, 32'h2001047f);
      slow <= 1'b0;
      go(16'h119e, 16'h0000, 32'h12345678, 1'b0);
      check("blank", {m.got[4], m.got[5], m.got[6], m.got[7]}, 32'h0);
      rreg(`REG_RESP_VALUE, v);
      check("value in", v, 32'h3e8);
      rreg(`REG_RESP_KEY, v);
      check("resp key", v, 32'h119e);
    end
  endtask
  task t_index;
    begin
      wreg(`REG_TYPE, 32'h3);
      go(16'h2010, 16'h7703, 32'h0000fffe, 1'b0);
      check("index", {m.got[2], m.got[3]}, 32'h7703);
      go(16'h1010, 16'h0003, 32'h0, 1'b0);
      rreg(`REG_RESP_VALUE, v);
      check("signed", v, 32'hfffffffe);
      wreg(`REG_TYPE, 32'h6);
      go(16'h1010, 16'h0003, 32'h0, 1'b0);
      rreg(`REG_RESP_VALUE, v);
      check("unsigned", v, 32'h0000fffe);
      go(16'h3011, 16'h0000, 32'hcafe0001, 1'b0);
      rreg(`REG_RESP_VALUE, v);
      check("dword", v, 32'hcafe0001);
    end
  endtask
  task t_fault;
    begin
      go(16'h13ff, 16'h0000, 32'h0, 1'b0);
      check("fault st", st, 32'h0a);
      rreg(`REG_FAULT, v);
      check("fault code", v, 32'h0);
      rreg(`REG_RESP_KEY, v);
      check("fault key", v, 32'h73ff);
      go(16'h21fe, 16'h0000, 32'h0000ffff, 1'b0);
      check("limit st", st, 32'h0a);
      rreg(`REG_FAULT, v);
      check("limit code", v, 32'h2);
    end
  endtask
  task t_text;
    integer r;
    begin
      r = m.nrep;
      go(16'hf028, 16'h0400, 32'h0, 1'b0);
      check("read type6", st, 32'h12);
      go(16'hf028, 16'h0600, 32'h0, 1'b0);
      check("high six", st, 32'h12);
      check("silent", m.nrep, r);
      wreg(`REG_TYPE, 32'h209);
      go(16'hf028, 16'h0400, 32'h41420000, 1'b0);
      check("text len", len_byte, 32'h0c);
      check("text rd", {m.got[2], m.got[4], m.got[5]}, 32'h040000);
      rreg(`REG_RESP_KEY, v);
      check("text key", v, 32'hf028);
      go(16'hf028, 16'h0500, 32'h41420000, 1'b0);
      check("text wr", {m.got[2], m.got[4], m.got[5]}, 32'h054142);
    end
  endtask
  task t_bcast;
    integer r;
    begin
      r = m.nrep;
      go(16'h2010, 16'h0001, 32'h5, 1'b1);
      check("bc state", st, 32'h2);
      check("bc silent", m.nrep, r);
      mute <= 1'b1;
      go(16'h1010, 16'h0001, 32'h0, 1'b0);
      check("timeout", st, 32'h6);
      mute <= 1'b0;
      rreg(8'h30, v);
      check("unmapped", v, 32'h0);
      rreg(`REG_VALUE_LOW, v);
      check("write only", v, 32'h0);
    end
  endtask
  task close_out;
    begin
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    t_param;
    t_index;
    t_fault;
    t_text;
    t_bcast;
    close_out;
  end
  // watchdog
  initial begin
    #400000;
    n_errors = n_errors + 1;
    close_out;
  end
endmodule
